// >>> rtl/fisp_regs.vh
// register map, reset values and timing constants of the flash programming interface
// assumes a 32-bit avalon-mm slave with word-aligned byte addresses
`ifndef FISP_REGS_VH
`define FISP_REGS_VH
`define FISP_OFS_ADDR_HIGH 8'h00
`define FISP_OFS_ADDR_LOW 8'h04
`define FISP_OFS_READ_BYTE 8'h08
`define FISP_OFS_WRITE_BYTE 8'h0C
`define FISP_OFS_PULSE_TIMING 8'h10
`define FISP_OFS_CONTROL 8'h14
`define FISP_OFS_STATUS 8'h18
`define FISP_OFS_KEY 8'h1C
`define FISP_ADDR_RESET 8'h00
`define FISP_TIMING_RESET 8'h7B
`define FISP_TIMING_WMASK 8'h7F
`define FISP_KEY_PATTERN 6'h26
`define FISP_KEY_CYCLES 4'h8
`define FISP_BOOT_VECTOR 16'h0000
`define FISP_FLASH_VECTOR 16'h0000
`define FISP_BOOT_ROM_BYTES 1024
`define FISP_CMD_READ 2'h0
`define FISP_CMD_WRITE 2'h1
`define FISP_CMD_PAGE_ERASE 2'h2
`define FISP_CMD_MASS_ERASE 2'h3
`define FISP_CTRL_START 2
`define FISP_CTRL_BOOT_CODE 3
`define FISP_PULSE_UNIT 8'h20
`endif

// >>> rtl/fisp_top.v
// flash in-system programming register block with boot-source selection
// assumes an avalon-mm master on clk_sys_i and a flash array with a ready handshake
`timescale 1ns/1ps
`default_nettype none
`include "fisp_regs.vh"
module fisp_top (
   input wire clk_sys_i,
   input wire arst_n_i,
   input wire clk_en_i,
   input wire [7:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output reg [31:0] avs_readdata_o,
   output wire avs_waitrequest_o,
   output wire [1:0] avs_response_o,
   input wire boot_select_i,
   input wire exec_in_boot_i,
   input wire jump_to_boot_instruction_i,
   input wire instr_cycle_i,
   output reg [15:0] reset_vector_o,
   output reg reset_in_boot_o,
   output reg jump_enter_boot_o,
   output reg serial_cmd_watch_o,
   output reg [15:0] flash_addr_o,
   output reg [7:0] flash_wdata_o,
   output reg [1:0] flash_cmd_o,
   output reg flash_pulse_o,
   input wire [7:0] flash_rdata_i,
   input wire flash_ready_i,
   output wire fetch_stall_o
);
   localparam ST_IDLE = 2'h0;
   localparam ST_PULSE = 2'h1;
   localparam ST_WAIT = 2'h2;

   reg [1:0] rst_sync_q;
   wire rst_n;
   reg [7:0] flash_addr_high_q;
   reg [7:0] flash_addr_low_q;
   reg [7:0] flash_read_byte_q;
   reg [7:0] flash_write_byte_q;
   reg [7:0] flash_pulse_timing_q;
   reg [1:0] hidden_program_control_q;
   reg [1:0] state_q;
   reg [15:0] pulse_cnt_q;
   reg [3:0] key_cnt_q;
   reg strap_done_q;
   reg ack_q;
   reg err_q;
   reg [31:0] rdata_d;
   wire busy;
   wire acc;
   wire wr_lo;
   wire [7:0] wb;
   wire key_armed;
   wire ctrl_access;
   wire op_start;

   // strobes honoured only on byte lane 0; registers are at most 8 bits wide
   function mapped;
      input [7:0] a;
      begin
         mapped = (a[1:0] == 2'h0) && (a <= `FISP_OFS_KEY);
      end
   endfunction

   // pulse length in core clocks; a zero timing value still gives one unit
   function [15:0] pulse_len;
      input [7:0] t;
      begin
         pulse_len = ({8'h00, t} | 16'h0001) * {8'h00, `FISP_PULSE_UNIT};
      end
   endfunction

   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // one wait cycle per access keeps the answer registered
   assign acc = (avs_read_i || avs_write_i) && !ack_q;
   assign avs_waitrequest_o = acc;
   assign avs_response_o = err_q ? 2'h2 : 2'h0;
   // writes land on the answer edge, where the master sees waitrequest low
   assign wr_lo = avs_write_i && ack_q && avs_byteenable_i[0] && mapped(avs_address_i);
   assign wb = avs_writedata_i[7:0];
   assign busy = (state_q != ST_IDLE);
   assign fetch_stall_o = busy;
   assign key_armed = (key_cnt_q != 4'h0);
   // hidden control only answers code running from boot rom
   assign ctrl_access = exec_in_boot_i && (avs_address_i == `FISP_OFS_CONTROL);
   assign op_start = wr_lo && ctrl_access && wb[`FISP_CTRL_START] && !busy;

   // bus handshake and registered readback
   always @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
         avs_readdata_o <= 32'h00000000;
      end else if (clk_en_i) begin
         ack_q <= acc;
         err_q <= acc && !mapped(avs_address_i);
         if (avs_read_i && acc) begin
            avs_readdata_o <= rdata_d;
         end
      end
   end

   // readback selection; key reads zero, control reads zero outside boot code
   always @* begin
      rdata_d = 32'h00000000;
      case (avs_address_i)
         `FISP_OFS_ADDR_HIGH: begin
            rdata_d = {24'h000000, flash_addr_high_q};
         end
         `FISP_OFS_ADDR_LOW: begin
            rdata_d = {24'h000000, flash_addr_low_q};
         end
         `FISP_OFS_READ_BYTE: begin
            rdata_d = {24'h000000, flash_read_byte_q};
         end
         `FISP_OFS_WRITE_BYTE: begin
            rdata_d = {24'h000000, flash_write_byte_q};
         end
         `FISP_OFS_PULSE_TIMING: begin
            rdata_d = {24'h000000, flash_pulse_timing_q};
         end
         `FISP_OFS_CONTROL: begin
            if (exec_in_boot_i) begin
               rdata_d = {30'h0, hidden_program_control_q};
            end
         end
         `FISP_OFS_STATUS: begin
            rdata_d = {29'h0, key_armed, reset_in_boot_o, busy};
         end
         default: begin
            rdata_d = 32'h00000000;
         end
      endcase
   end

   // software-visible registers; copied to the request fields at start, so firmware may change them during an operation
   always @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         flash_addr_high_q <= `FISP_ADDR_RESET;
         flash_addr_low_q <= `FISP_ADDR_RESET;
         flash_pulse_timing_q <= `FISP_TIMING_RESET;
         flash_write_byte_q <= 8'h00;
         hidden_program_control_q <= `FISP_CMD_READ;
      end else if (clk_en_i) begin
         if (wr_lo) begin
            case (avs_address_i)
               `FISP_OFS_ADDR_HIGH: begin
                  flash_addr_high_q <= wb;
               end
               `FISP_OFS_ADDR_LOW: begin
                  flash_addr_low_q <= wb;
               end
               `FISP_OFS_WRITE_BYTE: begin
                  flash_write_byte_q <= wb;
               end
               `FISP_OFS_PULSE_TIMING: begin
                  // bit 7 is read-only and keeps its reset value
                  flash_pulse_timing_q <= (wb & `FISP_TIMING_WMASK)
                     | (flash_pulse_timing_q & ~`FISP_TIMING_WMASK);
               end
               `FISP_OFS_CONTROL: begin
                  if (exec_in_boot_i) begin
                     hidden_program_control_q <= wb[1:0];
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // boot-entry key; a fresh key write wins over the countdown in the same cycle
   always @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         key_cnt_q <= 4'h0;
      end else if (clk_en_i) begin
         if (wr_lo && avs_address_i == `FISP_OFS_KEY && wb[7:2] == `FISP_KEY_PATTERN) begin
            key_cnt_q <= `FISP_KEY_CYCLES;
         end else if (instr_cycle_i && key_armed) begin
            key_cnt_q <= key_cnt_q - 4'h1;
         end
      end
   end

   // boot source latched once after reset release; later strap changes are ignored
   always @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         strap_done_q <= 1'b0;
         reset_in_boot_o <= 1'b1;
         reset_vector_o <= `FISP_BOOT_VECTOR;
      end else if (clk_en_i) begin
         if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            // the rom image lives outside; only the entry is steered here
            reset_in_boot_o <= !boot_select_i;
            reset_vector_o <= boot_select_i ? `FISP_FLASH_VECTOR : `FISP_BOOT_VECTOR;
         end
      end
   end

   // execution-state outputs follow the core one cycle late
   always @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         serial_cmd_watch_o <= 1'b0;
         jump_enter_boot_o <= 1'b0;
      end else if (clk_en_i) begin
         serial_cmd_watch_o <= exec_in_boot_i;
         jump_enter_boot_o <= jump_to_boot_instruction_i && key_armed;
      end
   end

   // read, write and erase pulse sequencer; fetches stall until the array answers
   always @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         pulse_cnt_q <= 16'h0000;
         flash_pulse_o <= 1'b0;
      end else if (clk_en_i) begin
         case (state_q)
            ST_IDLE: begin
               if (op_start) begin
                  pulse_cnt_q <= pulse_len(flash_pulse_timing_q);
                  flash_pulse_o <= 1'b1;
                  state_q <= ST_PULSE;
               end
            end
            ST_PULSE: begin
               if (pulse_cnt_q <= 16'h0001) begin
                  flash_pulse_o <= 1'b0;
                  state_q <= ST_WAIT;
               end else begin
                  pulse_cnt_q <= pulse_cnt_q - 16'h0001;
               end
            end
            ST_WAIT: begin
               if (flash_ready_i) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // request fields stand from one start until the next
   always @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         flash_addr_o <= 16'h0000;
         flash_wdata_o <= 8'h00;
         flash_cmd_o <= `FISP_CMD_READ;
      end else if (clk_en_i) begin
         if (op_start) begin
            flash_addr_o <= {flash_addr_high_q, flash_addr_low_q};
            flash_wdata_o <= flash_write_byte_q;
            flash_cmd_o <= wb[1:0];
         end
      end
   end

   // read result kept until the next read completes
   always @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         flash_read_byte_q <= 8'h00;
      end else if (clk_en_i) begin
         if (state_q == ST_WAIT && flash_ready_i && flash_cmd_o == `FISP_CMD_READ) begin
            flash_read_byte_q <= flash_rdata_i;
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/fisp_chk_sva.sv
// port checker for fisp_top: bus answer, boot select, pulse start
// assumes clk_en_i high whenever requests are made
`timescale 1ns/1ps
`default_nettype none
module fisp_chk (
   input wire clk_sys_i,
   input wire arst_n_i,
   input wire [7:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [31:0] avs_readdata_o,
   input wire avs_waitrequest_o,
   input wire [1:0] avs_response_o,
   input wire boot_select_i,
   input wire exec_in_boot_i,
   input wire jump_to_boot_instruction_i,
   input wire [15:0] reset_vector_o,
   input wire reset_in_boot_o,
   input wire jump_enter_boot_o,
   input wire flash_pulse_o,
   input wire fetch_stall_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   wire req = avs_read_i | avs_write_i;
   wire ans = req & !avs_waitrequest_o;
   wire start = ans & avs_write_i & avs_address_i == 8'h14 & avs_writedata_i[2] & !fetch_stall_o;
   chk_wait_first: assert property ($rose(req) |-> avs_waitrequest_o)
      else $error("no wait state");
   chk_one_wait: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("late answer");
   chk_read_upper: assert property (ans && avs_read_i |-> avs_readdata_o[31:8] == 24'h0)
      else $error("read upper bits set");
   chk_unmapped_err: assert property (ans && avs_address_i == 8'h20 |-> avs_response_o == 2'h2)
      else $error("unmapped not refused");
   chk_boot_select: assert property ($rose(arst_n_i) |-> ##4 reset_in_boot_o == !boot_select_i)
      else $error("wrong boot source");
   chk_vector_zero: assert property (reset_vector_o == 16'h0000)
      else $error("vector not zero");
   chk_pulse_start: assert property (start && exec_in_boot_i |=> flash_pulse_o)
      else $error("pulse did not start");
   chk_ctrl_hidden: assert property (start && !exec_in_boot_i |=> !flash_pulse_o)
      else $error("control reached by user code");
   chk_stall_pulse: assert property (flash_pulse_o |-> fetch_stall_o)
      else $error("fetch not stalled");
   chk_jump_key: assert property (jump_enter_boot_o |-> $past(jump_to_boot_instruction_i))
      else $error("boot entry without jump");
   cover property (start && exec_in_boot_i);
   cover property (jump_enter_boot_o);
   cover property (ans && avs_address_i == 8'h20);
endmodule
bind fisp_top fisp_chk u_fisp_chk (.clk_sys_i, .arst_n_i, .avs_address_i, .avs_read_i,
   .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o,
   .boot_select_i, .exec_in_boot_i, .jump_to_boot_instruction_i, .reset_vector_o,
   .reset_in_boot_o, .jump_enter_boot_o, .flash_pulse_o, .fetch_stall_o);
`default_nettype wire

// >>> tb/fisp_flash_model.sv
// flash array stand-in: ready strobe with read data DLY cycles after each pulse
// assumes pulse and address come from fisp_top on the same clock
`timescale 1ns/1ps
`default_nettype none
module fisp_flash_model #(
   parameter int DLY = 3
) (
   input wire logic clk_i,
   input wire logic pulse_i,
   input wire logic [15:0] addr_i,
   output var logic ready_o = 1'b0,
   output var logic [7:0] rdata_o = 8'h00
);
   logic pulse_q = 1'b0;
   int cnt_q = 0;
   always @(posedge clk_i) begin
      pulse_q <= pulse_i;
      cnt_q <= (pulse_q && !pulse_i) ? DLY : (cnt_q > 0) ? cnt_q - 1 : 0;
      ready_o <= (cnt_q == 1);
      // data toggles outside ready so a stale byte never matches
      rdata_o <= (cnt_q == 1) ? addr_i[7:0] ^ 8'h5A : ~rdata_o;
   end
endmodule
`default_nettype wire

// >>> tb/tb_fisp_top.sv
// self-checking bench for fisp_top with a flash array stand-in
// assumes the checker is bound from its own file
`timescale 1ns/1ps
`default_nettype none
module tb_fisp_top;
   logic clk_sys_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [7:0] avs_address_i = 8'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic boot_select_i = 1'b0;
   logic exec_in_boot_i = 1'b0;
   logic jump_to_boot_instruction_i = 1'b0;
   logic instr_cycle_i = 1'b0;
   logic serial_cmd_watch_o;
   logic [1:0] flash_cmd_o;
   logic [15:0] reset_vector_o;
   logic [31:0] avs_readdata_o, rd_q;
   logic avs_waitrequest_o, reset_in_boot_o, jump_enter_boot_o, flash_pulse_o;
   logic fetch_stall_o, flash_ready_i;
   logic [1:0] avs_response_o, rs_q;
   logic [15:0] flash_addr_o;
   logic [7:0] flash_wdata_o, flash_rdata_i;
   int fail_count = 0, n_checks = 0, pw = 0;
   logic [31:0] rows [6] = '{32'h005A5A00, 32'h04C3C300, 32'h0CA5A500, 32'h10FF7F00,
      32'h1C980000, 32'h20110002};
   always #10 clk_sys_i = ~clk_sys_i;
   always @(negedge clk_sys_i) pw += (flash_pulse_o === 1'b1);
   fisp_top u_fisp_top (.clk_sys_i, .arst_n_i, .clk_en_i(1'b1), .avs_address_i, .avs_read_i,
      .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o,
      .avs_waitrequest_o, .avs_response_o, .boot_select_i, .exec_in_boot_i,
      .jump_to_boot_instruction_i, .instr_cycle_i, .reset_vector_o,
      .reset_in_boot_o, .jump_enter_boot_o, .serial_cmd_watch_o, .flash_addr_o,
      .flash_wdata_o, .flash_cmd_o, .flash_pulse_o, .flash_rdata_i, .flash_ready_i,
      .fetch_stall_o);
   fisp_flash_model u_fisp_flash_model (.clk_i(clk_sys_i), .pulse_i(flash_pulse_o),
      .addr_i(flash_addr_o), .ready_o(flash_ready_i), .rdata_o(flash_rdata_i));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic hang;
      chk("timeout", 32'h0, 32'h1);
      complete_run();
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_sys_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= !w;
      for (k = 0; k < 50; k++) begin
         @(posedge clk_sys_i);
         if (avs_waitrequest_o === 1'b0) break;
      end
      if (k == 50) hang();
      rd_q = avs_readdata_o;
      rs_q = avs_response_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask
   task automatic jmp(input logic exp);
      @(posedge clk_sys_i);
      jump_to_boot_instruction_i <= 1'b1;
      @(posedge clk_sys_i);
      jump_to_boot_instruction_i <= 1'b0;
      @(negedge clk_sys_i);
      chk("jump", jump_enter_boot_o, exp);
   endtask
   task automatic rst(input logic b);
      @(posedge clk_sys_i);
      boot_select_i <= b;
      arst_n_i <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk("boot", reset_in_boot_o, !b);
      chk("vector", reset_vector_o, 32'h0);
      bus(1'b0, 8'h00, 32'h0);
      chk("adhi", rd_q, 32'h0);
      bus(1'b0, 8'h04, 32'h0);
      chk("adlo", rd_q, 32'h0);
      bus(1'b0, 8'h10, 32'h0);
      chk("timing", rd_q, 32'h7B);
      jmp(1'b0);
      $display("reset test done");
   endtask
   task automatic instr(input int n);
      repeat (n) begin
         @(posedge clk_sys_i);
         instr_cycle_i <= 1'b1;
         @(posedge clk_sys_i);
         instr_cycle_i <= 1'b0;
      end
   endtask
   // loads the address, starts an operation and polls busy; registers held meanwhile
   task automatic op(input logic [31:0] c, input logic [7:0] hi, input logic [7:0] lo);
      int k;
      bus(1'b1, 8'h00, {24'h0, hi});
      bus(1'b1, 8'h04, {24'h0, lo});
      pw = 0;
      bus(1'b1, 8'h14, c);
      for (k = 0; k < 100; k++) begin
         bus(1'b0, 8'h18, 32'h0);
         if (rd_q[0] === 1'b0) break;
      end
      if (k == 100) hang();
   endtask
   initial begin
      rst(1'b0);
      foreach (rows[j]) begin
         bus(1'b1, rows[j][31:24], {24'h0, rows[j][23:16]});
         bus(1'b0, rows[j][31:24], 32'h0);
         chk("rdata", rd_q, {24'h0, rows[j][15:8]});
         chk("resp", rs_q, rows[j][1:0]);
      end
      $display("register rows done");
      jmp(1'b1);
      instr(7);
      jmp(1'b1);
      instr(1);
      jmp(1'b0);
      @(posedge clk_sys_i);
      exec_in_boot_i <= 1'b1;
      bus(1'b1, 8'h10, 32'h1);
      chk("watch", serial_cmd_watch_o, 32'h1);
      op(32'h4, 8'h12, 8'h34);
      chk("width", pw, 32'd32);
      chk("faddr", flash_addr_o, 32'h1234);
      chk("fwdata", flash_wdata_o, 32'hA5);
      chk("fcmd", flash_cmd_o, 32'h0);
      bus(1'b0, 8'h08, 32'h0);
      chk("rbyte", rd_q, 32'h6E);
      op(32'h5, 8'h12, 8'h34);
      chk("fcmd", flash_cmd_o, 32'h1);
      bus(1'b0, 8'h08, 32'h0);
      chk("rkeep", rd_q, 32'h6E);
      op(32'h6, 8'h12, 8'h00);
      chk("page", {flash_cmd_o, flash_addr_o}, 32'h21200);
      op(32'h7, 8'h00, 8'h00);
      chk("mass", {flash_cmd_o, flash_addr_o}, 32'h30000);
      bus(1'b0, 8'h14, 32'h0);
      chk("ctrl", rd_q, 32'h3);
      op(32'h4, 8'hFF, 8'hFF);
      bus(1'b0, 8'h08, 32'h0);
      chk("option", rd_q, 32'hA5);
      @(posedge clk_sys_i);
      exec_in_boot_i <= 1'b0;
      bus(1'b1, 8'h14, 32'h4);
      @(negedge clk_sys_i);
      chk("hidden", fetch_stall_o, 32'h0);
      bus(1'b0, 8'h14, 32'h0);
      chk("ctrlusr", rd_q, 32'h0);
      chk("watch", serial_cmd_watch_o, 32'h0);
      $display("flash tests done");
      rst(1'b1);
      complete_run();
   end
endmodule
`default_nettype wire
